/* hw/tcd_regs.svh */
// Register indices, field positions and constants of the timer capture block
`ifndef TCD_REGS_SVH
`define TCD_REGS_SVH

// Register indices; the byte address is four times the index
`define TCD_IDX_W 8
`define TCD_IDX_CTRL1 8'h01
`define TCD_IDX_CTRL2 8'h02
`define TCD_IDX_RLD_LO 8'h06
`define TCD_IDX_RLD_HI 8'h07
`define TCD_IDX_WCAP_LO 8'h08
`define TCD_IDX_WCAP_HI 8'h09
`define TCD_IDX_NCAP_LO 8'h0A
`define TCD_IDX_NCAP_HI 8'h0B
`define TCD_IDX_IRQ_STAT 8'h10
`define TCD_IDX_IRQ_EN 8'h11
`define TCD_IDX_IRQ_CLR 8'h12

// First timer control fields
`define TCD_C1_ST_RISE 0
`define TCD_C1_ST_FALL 1
`define TCD_C1_EDGE_LO 4
`define TCD_C1_EDGE_HI 5
`define TCD_C1_N_EN 7

// Second timer control fields
`define TCD_C2_W_EN 0
`define TCD_C2_DEMOD 1
`define TCD_C2_CAP_IE 2

// Interrupt status bits
`define TCD_IRQ_W 3
`define TCD_IRQ_WCAP 0
`define TCD_IRQ_WTMO 1
`define TCD_IRQ_NCAP 2

// Reset values and fixed counts
`define TCD_RST_BYTE 8'h00
`define TCD_RST_IRQ 3'h0
`define TCD_ALL_ONES16 16'hFFFF
`define TCD_ONE16 16'h0001
`define TCD_ZERO16 16'h0000
`define TCD_ONE8 8'h01
`define TCD_ZERO8 8'h00

// Bus answers
`define TCD_RESP_OKAY 2'h0
`define TCD_RESP_SLVERR 2'h2
`define TCD_ZERO32 32'h0000_0000

`endif

/* hw/tcd_pkg.sv */
// Types shared by the timer capture block
package tcd_pkg;

  // Demodulation sequencer states
  typedef enum logic [2:0] {
    TCD_ST_IDLE = 3'b001,
    TCD_ST_ARMED = 3'b010,
    TCD_ST_COUNT = 3'b100
  } tcd_state_e;

  // Qualifying edge selection
  typedef enum logic [1:0] {
    TCD_EDGE_RISE = 2'b00,
    TCD_EDGE_FALL = 2'b01,
    TCD_EDGE_BOTH = 2'b10,
    TCD_EDGE_BOTH_ALT = 2'b11
  } tcd_edge_e;

endpackage

/* hw/tcd_edge_sync.sv */
// Two-stage synchroniser with edge detection for the timer input pin
`timescale 1ns/1ps
`default_nettype none

module tcd_edge_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Asynchronous pin
  input wire logic pin_i,
  // Synchronised level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta;
  logic stable;
  logic prev;

  // Only the second stage reads the first one
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else if (ce_i) begin
      meta <= pin_i;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edges from the settled stages only
  assign level_o = stable;
  assign rise_o = stable & ~prev;
  assign fall_o = ~stable & prev;

endmodule

`default_nettype wire

/* hw/tcd_timer.sv */
// Narrow and wide counter/timer capture logic with demodulation and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "tcd_regs.svh"

module tcd_timer
  import tcd_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int WIDE_W = 16,
  parameter int NARROW_W = 8
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Timer input pin
  input wire logic timer_in_i,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt and timer status
  output logic irq_o,
  output logic wide_timeout_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word index from a byte address; upper bits beyond the map make it unmapped
  function automatic logic [`TCD_IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[`TCD_IDX_W+1:2];
  endfunction

  function automatic logic idx_in_range(input logic [ADDR_W-1:0] addr);
    idx_in_range = (addr >> (`TCD_IDX_W + 2)) == '0;
  endfunction

  // Whether an edge qualifies under the selected edge mode
  function automatic logic edge_hit(input tcd_edge_e sel, input logic rise, input logic fall);
    unique case (sel)
      TCD_EDGE_RISE: edge_hit = rise;
      TCD_EDGE_FALL: edge_hit = fall;
      TCD_EDGE_BOTH, TCD_EDGE_BOTH_ALT: edge_hit = rise | fall;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] rld_lo;
  logic [7:0] rld_hi;
  logic [7:0] wcap_lo;
  logic [7:0] wcap_hi;
  logic [NARROW_W-1:0] ncap_lo;
  logic [NARROW_W-1:0] ncap_hi;
  logic [`TCD_IRQ_W-1:0] irq_stat;
  logic [`TCD_IRQ_W-1:0] irq_en;
  logic [WIDE_W-1:0] wide_cnt;
  logic [NARROW_W-1:0] narrow_cnt;
  tcd_state_e state;
  tcd_edge_e edge_sel;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [`TCD_IDX_W-1:0] wr_idx;
  logic wr_mapped;
  logic wr_lane0;
  logic [7:0] wr_byte;
  logic [`TCD_IDX_W-1:0] rd_idx;
  logic rd_fire;

  logic wide_en;
  logic demod;
  logic qual_edge;
  logic cap_event;
  logic tmo_event;
  logic narrow_cap;
  logic [WIDE_W-1:0] reload_val;
  logic [WIDE_W-1:0] next_cnt_dec;
  logic [WIDE_W-1:0] cap_val;
  logic [`TCD_IRQ_W-1:0] irq_set;
  logic [`TCD_IRQ_W-1:0] irq_clr;
  logic [`TCD_IRQ_W-1:0] irq_gate;

  ////////////////////////////////////////////////////////////////////////////
  // Input pin

  tcd_edge_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(timer_in_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  // Address and data are taken in either order, then held until the write
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= `TCD_ZERO32;
      w_strb <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write happens once both halves are in and no response is pending
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr);
  assign wr_lane0 = w_strb[0];
  assign wr_byte = w_data[7:0];

  always_comb begin
    wr_mapped = 1'b0;
    if (idx_in_range(aw_addr)) begin
      unique case (wr_idx)
        `TCD_IDX_CTRL1, `TCD_IDX_CTRL2, `TCD_IDX_RLD_LO, `TCD_IDX_RLD_HI,
        `TCD_IDX_WCAP_LO, `TCD_IDX_WCAP_HI, `TCD_IDX_NCAP_LO, `TCD_IDX_NCAP_HI,
        `TCD_IDX_IRQ_STAT, `TCD_IDX_IRQ_EN, `TCD_IDX_IRQ_CLR: wr_mapped = 1'b1;
        default: wr_mapped = 1'b0;
      endcase
    end
  end

  // Ready drops while a half is held, so each channel takes one item
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCD_RESP_OKAY;
    end else if (ce_i) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `TCD_RESP_OKAY : `TCD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = reg_index(s_axi_araddr);

  // One read at a time; data is sampled at the accepting edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `TCD_ZERO32;
      s_axi_rresp <= `TCD_RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TCD_RESP_OKAY;
        s_axi_rdata <= `TCD_ZERO32;
        if (!idx_in_range(s_axi_araddr)) begin
          s_axi_rresp <= `TCD_RESP_SLVERR;
        end else begin
          unique case (rd_idx)
            `TCD_IDX_CTRL1: s_axi_rdata[7:0] <= ctrl1;
            `TCD_IDX_CTRL2: s_axi_rdata[7:0] <= ctrl2;
            `TCD_IDX_RLD_LO: s_axi_rdata[7:0] <= rld_lo;
            `TCD_IDX_RLD_HI: s_axi_rdata[7:0] <= rld_hi;
            `TCD_IDX_WCAP_LO: s_axi_rdata[7:0] <= wcap_lo;
            `TCD_IDX_WCAP_HI: s_axi_rdata[7:0] <= wcap_hi;
            `TCD_IDX_NCAP_LO: s_axi_rdata[7:0] <= ncap_lo;
            `TCD_IDX_NCAP_HI: s_axi_rdata[7:0] <= ncap_hi;
            `TCD_IDX_IRQ_STAT: s_axi_rdata[`TCD_IRQ_W-1:0] <= irq_stat;
            `TCD_IDX_IRQ_EN: s_axi_rdata[`TCD_IRQ_W-1:0] <= irq_en;
            `TCD_IDX_IRQ_CLR: s_axi_rdata <= `TCD_ZERO32; // Write-only, reads zero
            default: s_axi_rresp <= `TCD_RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers

  // Hold and control bytes; capture registers have no write path
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl2 <= `TCD_RST_BYTE;
      rld_lo <= `TCD_RST_BYTE;
      rld_hi <= `TCD_RST_BYTE;
      irq_en <= `TCD_RST_IRQ;
    end else if (ce_i && wr_fire && wr_lane0) begin
      unique case (wr_idx)
        `TCD_IDX_CTRL2: ctrl2 <= wr_byte;
        `TCD_IDX_RLD_LO: rld_lo <= wr_byte; // Written mid-reload gives an undefined count
        `TCD_IDX_RLD_HI: rld_hi <= wr_byte;
        `TCD_IDX_IRQ_EN: irq_en <= wr_byte[`TCD_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // First control: mode bits written, edge status set by capture, write 1 clears
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl1 <= `TCD_RST_BYTE;
    end else if (ce_i) begin
      if (wr_fire && wr_lane0 && wr_idx == `TCD_IDX_CTRL1) begin
        ctrl1[7:2] <= wr_byte[7:2];
        ctrl1[1:0] <= ctrl1[1:0] & ~wr_byte[1:0];
      end
      // Set after the clear so a same-cycle capture wins
      if (cap_event && pin_rise) begin
        ctrl1[`TCD_C1_ST_RISE] <= 1'b1;
      end
      if (cap_event && pin_fall) begin
        ctrl1[`TCD_C1_ST_FALL] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Narrow timer: high and low phase measurement

  assign narrow_cap = ctrl1[`TCD_C1_N_EN] && (pin_rise || pin_fall);

  // Counter restarts at each input edge; phase length lands in its capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      narrow_cnt <= '0;
      ncap_hi <= '0;
      ncap_lo <= '0;
    end else if (ce_i) begin
      if (!ctrl1[`TCD_C1_N_EN]) begin
        narrow_cnt <= '0;
      end else if (pin_fall) begin
        ncap_hi <= narrow_cnt;
        narrow_cnt <= NARROW_W'(`TCD_ONE8);
      end else if (pin_rise) begin
        ncap_lo <= narrow_cnt;
        narrow_cnt <= NARROW_W'(`TCD_ONE8);
      end else begin
        narrow_cnt <= narrow_cnt + NARROW_W'(`TCD_ONE8);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wide timer

  assign wide_en = ctrl2[`TCD_C2_W_EN];
  assign demod = ctrl2[`TCD_C2_DEMOD];
  assign edge_sel = tcd_edge_e'(ctrl1[`TCD_C1_EDGE_HI:`TCD_C1_EDGE_LO]);
  assign qual_edge = edge_hit(edge_sel, pin_rise, pin_fall);
  assign reload_val = WIDE_W'({rld_hi, rld_lo});
  assign next_cnt_dec = wide_cnt - WIDE_W'(`TCD_ONE16);
  assign cap_val = ~wide_cnt;
  assign cap_event = ce_i && wide_en && demod && qual_edge && state != TCD_ST_IDLE;
  // Only the step from one ends a period; the wrap from zero does not
  assign tmo_event = ce_i && wide_en && !demod && state == TCD_ST_COUNT
                     && wide_cnt == WIDE_W'(`TCD_ONE16);

  // Sequencer and counter: modulo reload or demodulation capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= TCD_ST_IDLE;
      wide_cnt <= '0;
    end else if (ce_i) begin
      unique case (state)
        TCD_ST_IDLE: begin
          if (wide_en) begin
            wide_cnt <= reload_val;
            state <= demod ? TCD_ST_ARMED : TCD_ST_COUNT;
          end
        end
        TCD_ST_ARMED: begin
          if (!wide_en) begin
            state <= TCD_ST_IDLE;
          end else if (qual_edge) begin
            wide_cnt <= reload_val;
            state <= TCD_ST_COUNT;
          end
        end
        TCD_ST_COUNT: begin
          if (!wide_en) begin
            state <= TCD_ST_IDLE;
          end else if (demod && qual_edge) begin
            wide_cnt <= WIDE_W'(`TCD_ALL_ONES16);
          end else if (tmo_event) begin
            wide_cnt <= reload_val;
          end else begin
            wide_cnt <= next_cnt_dec; // Zero steps to all ones
          end
        end
      endcase
    end
  end

  // Wide captures take complemented count in demodulation mode only, when armed or counting
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wcap_hi <= `TCD_RST_BYTE;
      wcap_lo <= `TCD_RST_BYTE;
    end else if (cap_event) begin
      wcap_hi <= cap_val[15:8];
      wcap_lo <= cap_val[7:0];
    end
  end

  // Timeout pulse registered for the output
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wide_timeout_o <= 1'b0;
    end else if (ce_i) begin
      wide_timeout_o <= tmo_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irq_set = {narrow_cap, tmo_event, cap_event};
  assign irq_clr = (wr_fire && wr_lane0 && wr_idx == `TCD_IDX_IRQ_CLR)
                   ? wr_byte[`TCD_IRQ_W-1:0] : `TCD_RST_IRQ;
  // Wide capture also needs the second-control enable bit
  assign irq_gate = {1'b1, 1'b1, ctrl2[`TCD_C2_CAP_IE]};

  // Sticky status; a set in the clearing cycle survives
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_stat <= `TCD_RST_IRQ;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en & irq_gate);
    end
  end

endmodule

`default_nettype wire

/* verif/tcd_timer_properties.sv */
// Port-level checker of the timer capture block
`timescale 1ns/1ps
`default_nettype none
module tcd_timer_properties (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer status
  input wire logic wide_timeout_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Write: both halves on one edge, answer exactly two edges later
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_wr_answer;
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  // Unmapped reads must not leak stale data
  property p_slverr_data;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_tmo_pulse;
    wide_timeout_o |=> !wide_timeout_o;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_wr_answer: assert property (p_wr_answer) else $error("write answer not two edges later");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  a_r_byte: assert property (p_r_byte) else $error("read data above byte 0");
  a_slverr_data: assert property (p_slverr_data) else $error("error read with data");
  a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
  a_w_block: assert property (p_w_block) else $error("write taken while answer pending");
  a_b_drop: assert property (p_b_drop) else $error("write answer held after take");
  a_r_drop: assert property (p_r_drop) else $error("read answer held after take");
  a_tmo_pulse: assert property (p_tmo_pulse) else $error("timeout longer than a cycle");
endmodule
bind tcd_timer tcd_timer_properties i_tcd_timer_properties (.core_clk_i, .rst_n_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .wide_timeout_o);
`default_nettype wire

/* verif/tcd_pulse_model.sv */
// Behavioural source of the pulse train on the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tcd_pulse_model (
  // Clock that times the pulses
  input wire logic clk_i,
  // Pin level, idle low
  output logic pin_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle low; widths well above the minimum so every edge is seen
  initial pin_o = 1'b0;
  // High for hi cycles, then low for lo; call just after a rising edge
  task automatic pulse(input int hi, input int lo);
    pin_o <= 1'b1;
    repeat (hi) @(posedge clk_i);
    pin_o <= 1'b0;
    repeat (lo) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Directed testbench of the timer capture block
`timescale 1ns/1ps
`default_nettype none
`include "tcd_regs.svh"
module tb;
  logic clk, rst_n, ce, pin, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, tmo;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and pulse source
  tcd_timer i_tcd_timer (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .timer_in_i(pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_o(irq), .wide_timeout_o(tmo));
  tcd_pulse_model i_tcd_pulse_model (.clk_i(clk), .pin_o(pin));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bus write; bready raised early so the answer is taken on sight
  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er = 2'h0);
    int i;
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
    int i;
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // Cycles until the next timeout pulse, bounded
  task automatic gap(output int k);
    k = 0;
    while (tmo !== 1'b1 && k < 70000) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the long full-count test
  initial begin
    #1700000;
    error_cnt++;
    $display("BAD watchdog expected end seen hang");
    end_sim();
  end
  // Main sequence
  initial begin
    logic [15:0] ex;
    logic [1:0] m;
    int k;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    ce = 1'b1;
    {awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TCD_IDX_CTRL1, `TCD_RST_BYTE);
    rd(`TCD_IDX_IRQ_STAT, 8'h00);
    rd(8'h20, 8'h00, `TCD_RESP_SLVERR);
    wr(8'h20, 8'hA5, `TCD_RESP_SLVERR);
    $display("test bus done");
    wr(`TCD_IDX_CTRL1, 8'h80);
    i_tcd_pulse_model.pulse(20, 30);
    i_tcd_pulse_model.pulse(20, 30);
    rd(`TCD_IDX_NCAP_HI, 8'd20);
    rd(`TCD_IDX_NCAP_LO, 8'd30);
    wr(`TCD_IDX_CTRL1, 8'h00);
    $display("test narrow done");
    wr(`TCD_IDX_RLD_LO, 8'hFF);
    wr(`TCD_IDX_RLD_HI, 8'hFF);
    // Rise, fall and both edge codes; the last capture in both is one high phase
    m = 2'd0;
    repeat (4) begin
      wr(`TCD_IDX_CTRL2, 8'h00);
      wr(`TCD_IDX_CTRL1, {2'b00, m, 4'h3});
      wr(`TCD_IDX_IRQ_CLR, 8'h07);
      wr(`TCD_IDX_CTRL2, 8'h07);
      i_tcd_pulse_model.pulse(300, 100);
      i_tcd_pulse_model.pulse(300, 100);
      // Count sits at all ones for the first cycle, so N cycles leave N-1 steps
      ex = (m[1] ? 16'd300 : 16'd400) - 16'd1;
      rd(`TCD_IDX_WCAP_HI, ex[15:8]);
      rd(`TCD_IDX_WCAP_LO, ex[7:0]);
      rd(`TCD_IDX_CTRL1, {2'b00, m, 2'b00, m != 2'd0, m != 2'd1});
      if (m == 2'd0) begin
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`TCD_IDX_IRQ_EN, 8'h01);
        repeat (3) @(posedge clk);
      end
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`TCD_IDX_IRQ_CLR, 8'h01);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      m++;
    end
    wr(`TCD_IDX_WCAP_LO, 8'h55);
    rd(`TCD_IDX_WCAP_LO, 8'h2B);
    wr(`TCD_IDX_NCAP_HI, 8'h55);
    rd(`TCD_IDX_NCAP_HI, 8'd20);
    $display("test demod done");
    wr(`TCD_IDX_CTRL2, 8'h00);
    wr(`TCD_IDX_RLD_HI, 8'h01);
    wr(`TCD_IDX_RLD_LO, 8'h02);
    wr(`TCD_IDX_CTRL2, 8'h01);
    gap(k);
    @(posedge clk);
    gap(k);
    chk("reload period", 32'd258, k + 1);
    // Freeze 20 edges right after a pulse; the next pulse must come 20 edges late
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    gap(k);
    chk("frozen period", 32'd278, k + 21);
    wr(`TCD_IDX_CTRL2, 8'h00);
    wr(`TCD_IDX_RLD_HI, 8'h00);
    wr(`TCD_IDX_RLD_LO, 8'h00);
    wr(`TCD_IDX_CTRL2, 8'h01);
    gap(k);
    chk("zero start span", 32'h1, {31'h0, k > 65530 && k < 65545});
    $display("test modulo done");
    end_sim();
  end
endmodule
`default_nettype wire
